// >>> hdl/startup_config_pkg.sv
package startup_config_pkg;

  // map byte offsets inside the configuration image
  localparam logic [4:0] REC_LOW_OFF       = 5'h00;
  localparam logic [4:0] REC_HIGH_OFF      = 5'h01;
  localparam logic [4:0] SAMPLE_FMT_OFF    = 5'h02;
  localparam logic [4:0] CONV_MODE0_OFF    = 5'h03;
  localparam logic [4:0] CONV_MODE1_OFF    = 5'h04;
  localparam logic [4:0] IO_SELECT_OFF     = 5'h05;
  localparam logic [4:0] BOOST_REPORT_OFF  = 5'h19;
  localparam int         MAP_BYTES         = 26;
  localparam logic [4:0] MAP_LAST          = 5'h19;

  // recognition pattern and eeprom bus addresses
  localparam logic [7:0] REC_LOW_VAL       = 8'hAA;
  localparam logic [7:0] REC_HIGH_VAL      = 8'h55;
  localparam logic [7:0] EEPROM_WR_ADDR    = 8'hA0;
  localparam logic [7:0] EEPROM_RD_ADDR    = 8'hA1;
  localparam logic [7:0] START_WORD_ADDR   = 8'h00;

  // field positions
  localparam int OUT_FMT_LSB   = 5;
  localparam int PHASE_INV_BIT = 4;
  localparam int WIDTH_LSB     = 2;
  localparam int STEREO_BIT    = 1;
  localparam int RATE_GO_BIT   = 0;
  localparam int TONE_LSB      = 5;
  localparam int DEEMPH_BIT    = 4;
  localparam int SWAP_BIT      = 3;
  localparam int SYNC_BIT      = 2;
  localparam int MUTE_BIT      = 1;
  localparam int CONV_RST_BIT  = 0;
  localparam int MODE_SEL_BIT  = 7;
  localparam int CLIP_EN_BIT   = 7;

  // reset values and the clipping ceiling of bass plus volume
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] CLIP_LIMIT = 8'h60;

  // timing: clock 25 MHz, init window up to 10 ms, i2c quarter bit 2500 ns
  localparam int CLK_KHZ         = 25000;
  localparam int INIT_TIME_MS    = 10;
  localparam int INIT_CYCLES_DEF = INIT_TIME_MS * CLK_KHZ;
  localparam int QUARTER_NS      = 2500;
  localparam int QUARTER_CYC     = (QUARTER_NS * CLK_KHZ + 999999) / 1000000;

  typedef enum logic [2:0] {
    OP_START,
    OP_STOP,
    OP_WRITE,
    OP_READ_ACK,
    OP_READ_NACK
  } i2c_op_t;

  // built-in maps, picked by the two select pins when no eeprom answers
  function automatic logic [7:0] builtin_map(input logic [1:0] sel, input logic [4:0] idx);
    logic [7:0] b;
    b = BYTE_RESET;
    unique case (idx)
      SAMPLE_FMT_OFF:   b = sel[0] ? 8'h0B : 8'h0F;
      CONV_MODE0_OFF:   b = {1'b0, sel, 5'h00};
      CONV_MODE1_OFF:   b = 8'h80;
      IO_SELECT_OFF:    b = sel[1] ? 8'h80 : 8'h00;
      BOOST_REPORT_OFF: b = (sel == 2'h3) ? 8'h00 : 8'h01;
      default:          b = BYTE_RESET;
    endcase
    return b;
  endfunction : builtin_map

endpackage : startup_config_pkg

// >>> hdl/i2c_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2c_cmd_if;
  import startup_config_pkg::*;
  logic       req;
  i2c_op_t    op;
  logic [7:0] wr_data;
  logic       done;
  logic [7:0] rd_data;
  logic       ack_ok;

  modport master (output req, output op, output wr_data,
                  input done, input rd_data, input ack_ok);
  modport engine (input req, input op, input wr_data,
                  output done, output rd_data, output ack_ok);
endinterface : i2c_cmd_if
`default_nettype wire

// >>> hdl/i2c_byte_engine.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_byte_engine
  import startup_config_pkg::*;
(
  // clock and reset
  input  wire logic     ref_clk,
  input  wire logic     sys_rst,
  // command side
  i2c_cmd_if.engine     cmd,
  // bus lines, release is high
  input  wire logic     scl_in,
  input  wire logic     sda_in,
  output var  logic     scl_rel,
  output var  logic     sda_rel
);
  logic       busy_reg;
  i2c_op_t    op_reg;
  logic [6:0] qcnt_reg;
  logic [1:0] quarter_reg;
  logic [3:0] bitn_reg;
  logic [7:0] shift_reg;
  logic       done_reg;
  logic       ack_reg;
  logic       cur_bit;
  logic       stretch;
  logic       last_q;

  assign cmd.done    = done_reg;
  assign cmd.rd_data = shift_reg;
  assign cmd.ack_ok  = ack_reg;

  // bit to put on sda for the current data bit; ack slot of a read drives ack or nack
  always_comb
  begin
    if (bitn_reg == 4'h8)
      cur_bit = (op_reg == OP_READ_NACK) || (op_reg == OP_WRITE);
    else
      cur_bit = (op_reg == OP_WRITE) ? shift_reg[7] : 1'b1;
  end

  // a slave holding scl low freezes the high quarters
  assign stretch = quarter_reg[0] ^ quarter_reg[1] && scl_rel && !scl_in;
  assign last_q  = (qcnt_reg == 7'(QUARTER_CYC - 1)) && !stretch;

  // line levels: sda only moves while scl is low, except in start and stop
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      scl_rel <= 1'b1;
      sda_rel <= 1'b1;
    end
    else if (busy_reg)
    begin
      unique case (op_reg)
        OP_START: {scl_rel, sda_rel} <= (quarter_reg == 2'h0) ? 2'b01 :
                                        (quarter_reg == 2'h1) ? 2'b11 :
                                        (quarter_reg == 2'h2) ? 2'b10 : 2'b00;
        OP_STOP:  {scl_rel, sda_rel} <= (quarter_reg == 2'h0) ? 2'b00 :
                                        (quarter_reg == 2'h1) ? 2'b10 : 2'b11;
        default:  {scl_rel, sda_rel} <= (quarter_reg == 2'h3) ? {1'b0, sda_rel} :
                                        {quarter_reg != 2'h0, cur_bit};
      endcase
    end
  end

  // quarter and bit sequencing, shift and acknowledge capture
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy_reg    <= 1'b0;
      op_reg      <= OP_START;
      qcnt_reg    <= 7'h00;
      quarter_reg <= 2'h0;
      bitn_reg    <= 4'h0;
      shift_reg   <= 8'h00;
      done_reg    <= 1'b0;
      ack_reg     <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (!busy_reg)
      begin
        if (cmd.req)
        begin
          busy_reg    <= 1'b1;
          op_reg      <= cmd.op;
          shift_reg   <= cmd.wr_data;
          qcnt_reg    <= 7'h00;
          quarter_reg <= 2'h0;
          bitn_reg    <= 4'h0;
        end
      end
      else if (!last_q)
      begin
        if (!stretch)
          qcnt_reg <= qcnt_reg + 7'h01;
      end
      else
      begin
        qcnt_reg    <= 7'h00;
        quarter_reg <= quarter_reg + 2'h1;
        // sample at the end of scl high, in the last cycle before it falls
        if (quarter_reg == 2'h2 && op_reg != OP_START && op_reg != OP_STOP)
        begin
          if (bitn_reg == 4'h8)
            ack_reg <= (op_reg == OP_WRITE) ? !sda_in : 1'b1;
          else
            shift_reg <= {shift_reg[6:0], sda_in};
        end
        if (quarter_reg == 2'h3)
        begin
          if (op_reg == OP_START || op_reg == OP_STOP || bitn_reg == 4'h8)
          begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
          else
            bitn_reg <= bitn_reg + 4'h1;
        end
      end
    end
  end

endmodule : i2c_byte_engine
`default_nettype wire

// >>> hdl/startup_config_loader.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - bass boost follows host request value
// - clipping prevention lowers bass gain
// - byte 19H zero hides bass boost
// - de-emphasis comes only from start-up map
// - wait up to 10 ms after reset
// - become bus master, read eeprom
// - eeprom valid only if AAH, 55H
// - valid eeprom map replaces built-in settings
// - otherwise two pins pick built-in map
// - chosen configuration frozen until next start-up
// - first two bytes hold recognition pattern
// - byte 2 bits 6:5 output format
// - byte 2 bit 4 phase inversion
// - byte 2 bits 3:2 sample width
// - byte 2 mono/stereo, rate-control start state
// - byte 3 bits 6:5 tone mode
// - byte 3 bit 4 de-emphasis
// - byte 3 bit 3 channel swap
// - byte 3 bit 2 sync or async
// - byte 3 mute and converter reset
// - byte 3 bit 7 reads 0
// - byte 4 bit 7 reads 1
module startup_config_loader
  import startup_config_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYCLES_DEF
)
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // eeprom bus, open drain, enables low while driving
  input  wire logic       scl_in,
  output var  logic       scl_out,
  output var  logic       scl_oe_n,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  // map select pins
  input  wire logic       map_select_pin_high,
  input  wire logic       map_select_pin_low,
  // host sound requests
  input  wire logic       bass_boost_req,
  input  wire logic [7:0] bass_gain_req,
  input  wire logic [7:0] volume_gain,
  // applied map bytes
  output var  logic [7:0] sample_format_control,
  output var  logic [7:0] converter_mode_first,
  output var  logic [7:0] converter_mode_second,
  // decoded settings
  output var  logic [1:0] serial_out_format,
  output var  logic       mono_phase_invert,
  output var  logic [1:0] sample_width,
  output var  logic       stereo_mode,
  output var  logic       rate_control_logic_go,
  output var  logic [1:0] tone_mode,
  output var  logic       deemph_on,
  output var  logic       channel_swap,
  output var  logic       async_converter_sync,
  output var  logic       mute_on,
  output var  logic       async_converter_reset,
  // sound feature state
  output var  logic       clip_prevent_en,
  output var  logic       boost_reported,
  output var  logic       low_freq_boost_on,
  output var  logic [7:0] bass_gain_out,
  // start-up status
  output var  logic       eeprom_found,
  output var  logic       config_done,
  output var  logic       usb_enable
);
  typedef enum logic [3:0] {
    S_INIT, S_START, S_DEVW, S_ADDR, S_RESTART, S_DEVR, S_READ, S_STOP, S_APPLY, S_RUN
  } load_state_t;

  load_state_t state_reg;
  logic [17:0] init_cnt_reg;
  logic        wait_reg;
  logic        req_reg;
  i2c_op_t     op_reg;
  logic [7:0]  wdata_reg;
  logic        nack_seen_reg;
  logic [4:0]  idx_reg;
  logic [7:0]  map_mem [0:MAP_BYTES-1];
  logic [7:0]  sfc_reg, cm0_reg, cm1_reg, iosel_reg, b19_reg;
  logic        found_reg, done_reg, usb_reg, boost_rep_reg, boost_reg;
  logic [7:0]  bass_reg, vol_d_reg;
  logic [1:0]  sel_reg;
  logic        scl_rel, sda_rel;
  logic        found_next;
  logic [8:0]  gain_sum;

  i2c_cmd_if cmd_bus ();

  assign cmd_bus.req     = req_reg;
  assign cmd_bus.op      = op_reg;
  assign cmd_bus.wr_data = wdata_reg;

  i2c_byte_engine engine (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cmd     (cmd_bus.engine),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .scl_rel (scl_rel),
    .sda_rel (sda_rel)
  );

  // pins are pure open drain: level low, enable follows the engine register
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = scl_rel;
  assign sda_oe_n = sda_rel;

  // only the exact pattern counts, and only if every address byte was acknowledged
  assign found_next = !nack_seen_reg && map_mem[REC_LOW_OFF] == REC_LOW_VAL
                      && map_mem[REC_HIGH_OFF] == REC_HIGH_VAL;

  // load sequence: wait, then one random read of the whole map from address 0
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg     <= S_INIT;
      init_cnt_reg  <= 18'h00000;
      wait_reg      <= 1'b0;
      req_reg       <= 1'b0;
      op_reg        <= OP_START;
      wdata_reg     <= 8'h00;
      nack_seen_reg <= 1'b0;
      idx_reg       <= 5'h00;
    end
    else
    begin
      req_reg <= 1'b0;
      unique case (state_reg)
        S_INIT:
        begin
          init_cnt_reg <= init_cnt_reg + 18'h00001;
          if (init_cnt_reg == 18'(INIT_CYCLES - 1))
            state_reg <= S_START;
        end
        S_APPLY: state_reg <= S_RUN;
        S_RUN:   state_reg <= S_RUN;
        default:
        begin
          if (!wait_reg)
          begin
            wait_reg <= 1'b1;
            req_reg  <= 1'b1;
            unique case (state_reg)
              S_START, S_RESTART: op_reg <= OP_START;
              S_STOP:             op_reg <= OP_STOP;
              S_READ:  op_reg <= (idx_reg == MAP_LAST) ? OP_READ_NACK : OP_READ_ACK;
              default: op_reg <= OP_WRITE;
            endcase
            wdata_reg <= (state_reg == S_DEVW) ? EEPROM_WR_ADDR :
                         (state_reg == S_DEVR) ? EEPROM_RD_ADDR : START_WORD_ADDR;
          end
          else if (cmd_bus.done)
          begin
            wait_reg <= 1'b0;
            unique case (state_reg)
              S_START:   state_reg <= S_DEVW;
              S_RESTART: state_reg <= S_DEVR;
              S_STOP:    state_reg <= S_APPLY;
              S_READ:
              begin
                idx_reg <= idx_reg + 5'h01;
                if (idx_reg == MAP_LAST)
                  state_reg <= S_STOP;
              end
              default:
              begin
                if (!cmd_bus.ack_ok)
                begin
                  nack_seen_reg <= 1'b1;
                  state_reg     <= S_STOP;
                end
                else
                  state_reg <= (state_reg == S_DEVW) ? S_ADDR :
                               (state_reg == S_ADDR) ? S_RESTART : S_READ;
              end
            endcase
          end
        end
      endcase
    end
  end

  // captured map image; unread bytes stay zero
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < MAP_BYTES; i++)
        map_mem[i] <= BYTE_RESET;
    end
    else if (state_reg == S_READ && wait_reg && cmd_bus.done)
      map_mem[idx_reg] <= cmd_bus.rd_data;
  end

  // apply once: eeprom image or pin-selected built-in map, then hold forever
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sfc_reg   <= BYTE_RESET;
      cm0_reg   <= BYTE_RESET;
      cm1_reg   <= BYTE_RESET;
      iosel_reg <= BYTE_RESET;
      b19_reg   <= BYTE_RESET;
      sel_reg   <= 2'h0;
      found_reg <= 1'b0;
      done_reg  <= 1'b0;
    end
    else if (state_reg == S_APPLY)
    begin
      found_reg <= found_next;
      sel_reg   <= {map_select_pin_high, map_select_pin_low};
      done_reg  <= 1'b1;
      if (found_next)
      begin
        sfc_reg   <= map_mem[SAMPLE_FMT_OFF];
        cm0_reg   <= map_mem[CONV_MODE0_OFF];
        cm1_reg   <= map_mem[CONV_MODE1_OFF];
        iosel_reg <= map_mem[IO_SELECT_OFF];
        b19_reg   <= map_mem[BOOST_REPORT_OFF];
      end
      else
      begin
        sfc_reg   <= builtin_map({map_select_pin_high, map_select_pin_low}, SAMPLE_FMT_OFF);
        cm0_reg   <= builtin_map({map_select_pin_high, map_select_pin_low}, CONV_MODE0_OFF);
        cm1_reg   <= builtin_map({map_select_pin_high, map_select_pin_low}, CONV_MODE1_OFF);
        iosel_reg <= builtin_map({map_select_pin_high, map_select_pin_low}, IO_SELECT_OFF);
        b19_reg   <= builtin_map({map_select_pin_high, map_select_pin_low}, BOOST_REPORT_OFF);
      end
    end
  end

  // usb function is held off one cycle past the apply so every setting is stable first
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      usb_reg <= 1'b0;
    else
      usb_reg <= done_reg;
  end

  // host bass boost switch, and the clipping guard on bass gain
  assign gain_sum = {1'b0, bass_gain_req} + {1'b0, volume_gain};
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      boost_reg     <= 1'b0;
      boost_rep_reg <= 1'b0;
      bass_reg      <= 8'h00;
      vol_d_reg     <= 8'h00;
    end
    else
    begin
      boost_rep_reg <= done_reg && (b19_reg != 8'h00);
      boost_reg     <= usb_reg && bass_boost_req;
      vol_d_reg     <= volume_gain;
      if (!usb_reg)
        bass_reg <= 8'h00;
      else if (iosel_reg[CLIP_EN_BIT] && gain_sum > {1'b0, CLIP_LIMIT})
        bass_reg <= (volume_gain >= CLIP_LIMIT) ? 8'h00 : CLIP_LIMIT - volume_gain;
      else
        bass_reg <= bass_gain_req;
    end
  end

  // outputs; the mode-select bits are fixed regardless of what the image holds
  assign sample_format_control = sfc_reg;
  assign converter_mode_first  = {1'b0, cm0_reg[6:0]};
  assign converter_mode_second = {1'b1, cm1_reg[6:0]};
  assign serial_out_format     = sfc_reg[OUT_FMT_LSB +: 2];
  assign mono_phase_invert     = sfc_reg[PHASE_INV_BIT];
  assign sample_width          = sfc_reg[WIDTH_LSB +: 2];
  assign stereo_mode           = sfc_reg[STEREO_BIT];
  assign rate_control_logic_go = sfc_reg[RATE_GO_BIT];
  assign tone_mode             = cm0_reg[TONE_LSB +: 2];
  assign deemph_on             = cm0_reg[DEEMPH_BIT];
  assign channel_swap          = cm0_reg[SWAP_BIT];
  assign async_converter_sync  = cm0_reg[SYNC_BIT];
  assign mute_on               = cm0_reg[MUTE_BIT];
  assign async_converter_reset = cm0_reg[CONV_RST_BIT];
  assign clip_prevent_en       = iosel_reg[CLIP_EN_BIT];
  assign boost_reported        = boost_rep_reg;
  assign low_freq_boost_on     = boost_reg;
  assign bass_gain_out         = bass_reg;
  assign eeprom_found          = found_reg;
  assign config_done           = done_reg;
  assign usb_enable            = usb_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  boost_follow_a: assert property (usb_reg && bass_boost_req |=> boost_reg)
    else $error("bass boost did not follow host request");
  clip_guard_a: assert property (usb_reg && $past(usb_reg) && iosel_reg[CLIP_EN_BIT]
      && vol_d_reg <= CLIP_LIMIT |-> ({1'b0, bass_reg} + {1'b0, vol_d_reg}) <= {1'b0, CLIP_LIMIT})
    else $error("bass plus volume above clip limit");
  boost_hidden_a: assert property ($rose(usb_reg) |=> boost_rep_reg == (b19_reg != 8'h00))
    else $error("bass boost report disagrees with map byte");
  bus_quiet_init_a: assert property (state_reg == S_INIT |-> scl_oe_n && sda_oe_n)
    else $error("bus driven during init window");
  eeprom_check_a: assert property ($rose(done_reg) && found_reg |-> map_mem[REC_LOW_OFF] == REC_LOW_VAL
      && map_mem[REC_HIGH_OFF] == REC_HIGH_VAL && !nack_seen_reg)
    else $error("eeprom accepted without pattern");
  fallback_pins_a: assert property ($rose(done_reg) && !found_reg |->
      sfc_reg == builtin_map(sel_reg, SAMPLE_FMT_OFF))
    else $error("fallback map does not match select pins");
  config_frozen_a: assert property (done_reg && $past(done_reg) |-> $stable(sfc_reg)
      && $stable(cm0_reg) && $stable(cm1_reg))
    else $error("configuration changed after apply");
  mode_select_a: assert property (!converter_mode_first[MODE_SEL_BIT]
      && converter_mode_second[MODE_SEL_BIT])
    else $error("mode register select bit wrong");
  nack_fallback_a: assert property ($rose(done_reg) && $past(nack_seen_reg) |-> !found_reg)
    else $error("eeprom used after missing acknowledge");
  usb_after_a: assert property ($rose(usb_reg) |-> $past(done_reg) && state_reg == S_RUN)
    else $error("usb enabled before configuration applied");

  eeprom_used_c: cover property ($rose(done_reg) && found_next);
  pins_used_c:   cover property ($rose(done_reg) && nack_seen_reg);
  clip_hit_c:    cover property (usb_reg && iosel_reg[CLIP_EN_BIT] && gain_sum > {1'b0, CLIP_LIMIT});

endmodule : startup_config_loader
`default_nettype wire

// >>> testbench/eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_model
(
  // bus wires, both pulled up
  input  wire logic scl,
  input  wire logic sda,
  // low leaves the bus address unanswered
  input  wire logic present,
  // low pulls sda low
  output var  logic sda_drv_n,
  // low holds scl low, as a slow device stretching the clock
  output var  logic scl_drv_n
);
  logic [7:0] mem [0:31];
  logic [7:0] sh;
  logic [7:0] dat;
  logic [4:0] ptr;
  logic       first;
  logic       rdp;
  logic       rd;
  logic       mack;
  int         cnt;

  initial
  begin
    sda_drv_n = 1'b1;
    scl_drv_n = 1'b1;
    cnt = 0;
    rd = 1'b0;
    rdp = 1'b0;
    mack = 1'b0;
    ptr = 5'h00;
  end

  // a start condition restarts byte framing, also a repeated one
  always @(negedge sda)
  begin
    if (scl === 1'b1)
    begin
      cnt = 0;
      first = 1'b1;
      rd = 1'b0;
      rdp = 1'b0;
      sda_drv_n = 1'b1;
    end
  end

  // bits are taken on the rising clock, msb first
  always @(posedge scl)
  begin
    if (cnt == 8)
      mack = sda;
    else if (!rd)
      sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end

  // data only changes while the clock is low, so no false start or stop
  always @(negedge scl)
  begin
    if (cnt == 8 && !rd)
    begin
      sda_drv_n = !present;
      if (first)
        rdp = (sh == 8'hA1);
      else
        ptr = sh[4:0];
      first = 1'b0;
    end
    else if (cnt == 9)
    begin
      cnt = 0;
      if (rdp)
        rd = 1'b1;
      else if (mack)
        rd = 1'b0;
      rdp = 1'b0;
      dat = mem[ptr];
      if (rd)
        ptr = ptr + 5'h01;
      sda_drv_n = rd ? dat[7] : 1'b1;
      // write acks except after the read address, and the last read, hold scl past two quarters, off the clock edge
      if (!rd && present)
      begin
        scl_drv_n = 1'b0;
        #8010 scl_drv_n = 1'b1;
      end
    end
    else if (rd && cnt < 8)
      sda_drv_n = dat[7 - cnt];
    else
      sda_drv_n = 1'b1;
  end
endmodule : eeprom_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import startup_config_pkg::*;
  localparam int INIT = 20;
  logic       ref_clk, sys_rst, present, map_select_pin_high, map_select_pin_low;
  logic       bass_boost_req, scl_in, sda_in;
  logic [8:0] exp_q [$];
  logic [7:0] bass_gain_req, volume_gain, eg;
  logic [7:0] exp_b [0:31];
  logic [31:0] r;
  int         num_errors, samples_checked, cyc, s;
  wire logic  sda_drv_n;
  wire logic  scl_drv_n;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, mono_phase_invert, stereo_mode;
  logic       rate_control_logic_go, deemph_on, channel_swap, async_converter_sync, mute_on;
  logic       async_converter_reset, clip_prevent_en, boost_reported, low_freq_boost_on;
  logic       eeprom_found, config_done, usb_enable;
  logic [1:0] serial_out_format, sample_width, tone_mode;
  logic [7:0] sample_format_control, converter_mode_first, converter_mode_second, bass_gain_out;

  // open drain wires with pull-ups
  assign scl_in = (scl_oe_n | scl_out) & scl_drv_n;
  assign sda_in = (sda_oe_n | sda_out) & sda_drv_n;

  startup_config_loader #(.INIT_CYCLES(INIT)) u_startup_config_loader (.ref_clk, .sys_rst,
    .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n, .map_select_pin_high,
    .map_select_pin_low, .bass_boost_req, .bass_gain_req, .volume_gain, .sample_format_control,
    .converter_mode_first, .converter_mode_second, .serial_out_format, .mono_phase_invert,
    .sample_width, .stereo_mode, .rate_control_logic_go, .tone_mode, .deemph_on, .channel_swap,
    .async_converter_sync, .mute_on, .async_converter_reset, .clip_prevent_en, .boost_reported,
    .low_freq_boost_on, .bass_gain_out, .eeprom_found, .config_done, .usb_enable);

  eeprom_model u_eeprom_model (.scl(scl_in), .sda(sda_in), .present, .sda_drv_n, .scl_drv_n);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // one full eeprom pass is about 67000 cycles, pin map passes far less
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      num_errors++;
      final_report;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    samples_checked++;
    if (got !== want)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : chk

  // one start-up from reset, then the applied map and the sound path
  task automatic run(input logic found);
    int n;
    sys_rst = 1'b1;
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (INIT - 2) @(negedge ref_clk);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    n = 0;
    while (config_done !== 1'b1 && n < 75000)
    begin
      if (n == 1000) chk({7'h00, usb_enable}, 8'h00);
      @(negedge ref_clk);
      n++;
    end
    chk({7'h00, config_done}, 8'h01);
    chk({7'h00, eeprom_found}, {7'h00, found});
    chk(sample_format_control, exp_b[2]);
    chk({1'b0, serial_out_format, mono_phase_invert, sample_width, stereo_mode,
         rate_control_logic_go}, {1'b0, exp_b[2][6:0]});
    chk({1'b0, tone_mode, deemph_on, channel_swap, async_converter_sync, mute_on,
         async_converter_reset}, {1'b0, exp_b[3][6:0]});
    chk(converter_mode_first, {1'b0, exp_b[3][6:0]});
    chk(converter_mode_second, {1'b1, exp_b[4][6:0]});
    chk({7'h00, clip_prevent_en}, {7'h00, exp_b[5][7]});
    @(negedge ref_clk);
    chk({7'h00, usb_enable}, 8'h01);
    chk({7'h00, boost_reported}, {7'h00, exp_b[25] != 8'h00});
    for (n = 0; n < 24; n++)
    begin
      r = $urandom;
      bass_boost_req = r[0];
      bass_gain_req = r[15:8];
      volume_gain = r[24] ? r[23:16] : {2'b00, r[21:16]};
      eg = bass_gain_req;
      if (exp_b[5][7] && int'(bass_gain_req) + int'(volume_gain) > int'(CLIP_LIMIT))
        eg = (volume_gain >= CLIP_LIMIT) ? 8'h00 : CLIP_LIMIT - volume_gain;
      exp_q.push_back({r[0], eg});
      @(negedge ref_clk);
      chk(bass_gain_out, exp_q[0][7:0]);
      chk({7'h00, low_freq_boost_on}, {7'h00, exp_q[0][8]});
      exp_q.delete(0);
    end
    // the select pins moving after the choice must change nothing
    map_select_pin_high = ~map_select_pin_high;
    map_select_pin_low = ~map_select_pin_low;
    repeat (4) @(negedge ref_clk);
    chk(sample_format_control, exp_b[2]);
    chk(converter_mode_first, {1'b0, exp_b[3][6:0]});
  endtask : run

  initial
  begin
    sys_rst = 1'b1;
    present = 1'b0;
    map_select_pin_high = 1'b0;
    map_select_pin_low = 1'b0;
    bass_boost_req = 1'b0;
    bass_gain_req = 8'h00;
    volume_gain = 8'h00;
    num_errors = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(32'hB8305CB2));
    // no eeprom answers: every pin selected map in turn
    for (s = 0; s < 4; s++)
    begin
      {map_select_pin_high, map_select_pin_low} = s[1:0];
      exp_b[2] = s[0] ? 8'h0B : 8'h0F;
      exp_b[3] = {1'b0, s[1:0], 5'h00};
      exp_b[4] = 8'h80;
      exp_b[5] = s[1] ? 8'h80 : 8'h00;
      exp_b[25] = (s == 3) ? 8'h00 : 8'h01;
      run(1'b0);
    end
    // valid eeprom with random contents, clipping on and boost hidden
    present = 1'b1;
    for (s = 0; s < 32; s++)
    begin
      r = $urandom;
      u_eeprom_model.mem[s] = r[7:0];
    end
    u_eeprom_model.mem[0] = REC_LOW_VAL;
    u_eeprom_model.mem[1] = REC_HIGH_VAL;
    u_eeprom_model.mem[5][7] = 1'b1;
    u_eeprom_model.mem[25] = 8'h00;
    for (s = 2; s < 32; s++)
      exp_b[s] = u_eeprom_model.mem[s];
    run(1'b1);
    final_report;
  end
endmodule : testbench
`default_nettype wire
